// [pkg/ssc_defines.svh]
// constants for the synchronous burst static ram control block
`ifndef SSC_DEFINES_SVH
`define SSC_DEFINES_SVH
// address width in words
`define SSC_AW 21
// number of byte lanes and bits per lane
`define SSC_LANES 4
`define SSC_BYTE_W 9
// data bus width
`define SSC_DW (`SSC_LANES * `SSC_BYTE_W)
// low address bits walked by the burst counter
`define SSC_BURST_W 2
// first burst index and the step between indices
`define SSC_IDX_FIRST 2'h0
`define SSC_IDX_STEP 2'h1
// edges from sleep request change to sleep entry or exit
`define SSC_SLEEP_CYC 2'h2
// sleep counter start value
`define SSC_SLEEP_START 2'h1
`endif

// [pkg/ssc_pkg.sv]
// types and helper functions for the burst static ram control block
`default_nettype none
`include "ssc_defines.svh"
package ssc_pkg;

  // kind of access held in a pipeline stage or remembered for continues
  typedef enum logic [1:0] {
    KIND_NONE  = 2'b00,
    KIND_READ  = 2'b01,
    KIND_WRITE = 2'b10,
    KIND_DESEL = 2'b11
  } ssc_kind_t;

  // sleep sequencing states
  typedef enum logic [1:0] {
    ST_ACTIVE = 2'b00,
    ST_ENTER  = 2'b01,
    ST_ASLEEP = 2'b10,
    ST_WAKE   = 2'b11
  } ssc_sleep_t;

  // one decoded access travelling down the pipeline
  typedef struct packed {
    ssc_kind_t kind;
    logic [`SSC_AW-1:0] addr;
    logic [`SSC_LANES-1:0] ben_n;
  } ssc_op_t;

  // straps caught once after reset
  typedef struct packed {
    logic flow;
    logic interleave;
    logic high_drive;
  } ssc_straps_t;

  // low address bits of burst access idx from the loaded base
  function automatic logic [`SSC_BURST_W-1:0] burst_low(
    input logic [`SSC_BURST_W-1:0] base,
    input logic [`SSC_BURST_W-1:0] idx,
    input logic ilv
  );
    burst_low = ilv ? (base ^ idx) : (base + idx);
  endfunction : burst_low

  // true when at least one active-low lane enable is asserted
  function automatic logic any_lane(input logic [`SSC_LANES-1:0] ben_n);
    any_lane = ~&ben_n;
  endfunction : any_lane

endpackage : ssc_pkg
`default_nettype wire

// [logic/ssc_burst_gen.sv]
// two-bit burst address generator, linear or interleaved
`default_nettype none
`include "ssc_defines.svh"
module ssc_burst_gen (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic load_i,
  input wire logic step_i,
  input wire logic [`SSC_BURST_W-1:0] start_i,
  input wire logic interleave_i,
  output logic [`SSC_BURST_W-1:0] next_o
);

  // loaded base and access index; the index wraps so four accesses close
  logic [`SSC_BURST_W-1:0] base_q, base_d;
  logic [`SSC_BURST_W-1:0] idx_q, idx_d;

  // next values: load restarts, step walks the index
  always_comb
  begin
    base_d = base_q;
    idx_d = idx_q;
    if (load_i)
    begin
      base_d = start_i;
      idx_d = `SSC_IDX_FIRST;
    end
    else if (step_i)
    begin
      idx_d = idx_q + `SSC_IDX_STEP;
    end
  end

  // register the counter
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      base_q <= `SSC_IDX_FIRST;
      idx_q <= `SSC_IDX_FIRST;
    end
    else
    begin
      base_q <= base_d;
      idx_q <= idx_d;
    end
  end

  // address the next continue will use
  assign next_o = ssc_pkg::burst_low(base_q, idx_q + `SSC_IDX_STEP,
                                     interleave_i);

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  burst_wrap_a: assert property (
    load_i ##1 (step_i && !load_i) [*4] |=> next_o == $past(next_o, 4))
    else $error("burst counter did not wrap after four accesses");

  linear_step_a: assert property (
    !interleave_i && step_i && !load_i
      |=> next_o == $past(next_o) + `SSC_IDX_STEP)
    else $error("linear burst did not add one");

  ilv_first_a: assert property (
    interleave_i && load_i |=> next_o == ($past(start_i) ^ `SSC_IDX_STEP))
    else $error("interleaved second address wrong");

endmodule : ssc_burst_gen
`default_nettype wire

// [logic/ssc_core.sv]
// command decode, burst address and data pipeline of the burst ram
`default_nettype none
`include "ssc_defines.svh"
module ssc_core (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic clock_hold_i,
  input wire logic load_or_advance_i,
  input wire logic write_n_i,
  input wire logic [`SSC_LANES-1:0] byte_lane_enables_n_i,
  input wire logic select_low_a_n_i,
  input wire logic select_high_i,
  input wire logic select_low_b_n_i,
  input wire logic out_enable_n_i,
  input wire logic sleep_request_i,
  input wire logic burst_order_select_i,
  input wire logic pass_through_select_n_i,
  input wire logic drive_strength_select_i,
  input wire logic [`SSC_AW-1:0] addr_i,
  input wire logic [`SSC_DW-1:0] dq_i,
  input wire logic [`SSC_DW-1:0] mem_rdata_i,
  output logic [`SSC_DW-1:0] dq_o,
  output logic dq_oe_o,
  output logic mem_re_o,
  output logic [`SSC_AW-1:0] mem_raddr_o,
  output logic mem_we_o,
  output logic [`SSC_AW-1:0] mem_waddr_o,
  output logic [`SSC_LANES-1:0] mem_wben_o,
  output logic [`SSC_DW-1:0] mem_wdata_o,
  output logic high_drive_o,
  output logic asleep_o
);

  // straps: reset values are the pulled defaults
  ssc_pkg::ssc_straps_t strap_q, strap_d;
  logic strap_taken_q, strap_taken_d;

  // sleep sequencer
  ssc_pkg::ssc_sleep_t st_q, st_d;
  logic [1:0] slp_cnt_q, slp_cnt_d;
  logic asleep_q, asleep_d;

  // decode results and burst bookkeeping
  ssc_pkg::ssc_op_t op_d;
  ssc_pkg::ssc_kind_t last_q, last_d;
  logic [`SSC_AW-1:`SSC_BURST_W] hi_q, hi_d;
  logic [`SSC_BURST_W-1:0] next_low;
  logic load, step;
  logic frozen;
  logic sel_ok;

  // pipeline stages and data path
  ssc_pkg::ssc_op_t s1_q, s1_d, s2_q, s2_d, wsrc;
  logic re_q, re_d;
  logic [`SSC_DW-1:0] rd_q, rd_d;
  logic [`SSC_DW-1:0] dq_q, dq_d;
  logic rdv_q, rdv_d;
  logic oe_q, oe_d;
  logic we_q, we_d;
  logic [`SSC_AW-1:0] waddr_q, waddr_d;
  logic [`SSC_LANES-1:0] wben_q, wben_d;
  logic [`SSC_DW-1:0] wdata_q, wdata_d;

  // straps are caught on the first edge after reset and then kept;
  // the pins are meant to be tied, so later changes are ignored
  always_comb
  begin
    strap_d = strap_q;
    strap_taken_d = 1'b1;
    if (!strap_taken_q)
    begin
      strap_d.flow = !pass_through_select_n_i;
      strap_d.interleave = burst_order_select_i;
      strap_d.high_drive = !drive_strength_select_i;
    end
  end

  // sleep sequencing: two edges in, two edges out
  always_comb
  begin
    st_d = st_q;
    slp_cnt_d = slp_cnt_q;
    unique case (st_q)
      ssc_pkg::ST_ACTIVE:
      begin
        if (sleep_request_i)
        begin
          st_d = ssc_pkg::ST_ENTER;
          slp_cnt_d = `SSC_SLEEP_START;
        end
      end
      ssc_pkg::ST_ENTER:
      begin
        slp_cnt_d = slp_cnt_q + `SSC_SLEEP_START;
        if (!sleep_request_i)
          st_d = ssc_pkg::ST_ACTIVE;
        else if (slp_cnt_d == `SSC_SLEEP_CYC)
          st_d = ssc_pkg::ST_ASLEEP;
      end
      ssc_pkg::ST_ASLEEP:
      begin
        if (!sleep_request_i)
        begin
          st_d = ssc_pkg::ST_WAKE;
          slp_cnt_d = `SSC_SLEEP_START;
        end
      end
      ssc_pkg::ST_WAKE:
      begin
        slp_cnt_d = slp_cnt_q + `SSC_SLEEP_START;
        if (sleep_request_i)
        begin
          st_d = ssc_pkg::ST_ENTER;
          slp_cnt_d = `SSC_SLEEP_START;
        end
        else if (slp_cnt_d == `SSC_SLEEP_CYC)
          st_d = ssc_pkg::ST_ACTIVE;
      end
    endcase
    asleep_d = (st_d == ssc_pkg::ST_ASLEEP);
  end

  // a held edge or sleep leaves every stage untouched
  assign frozen = clock_hold_i || (st_q == ssc_pkg::ST_ASLEEP);
  assign sel_ok = !select_low_a_n_i && select_high_i && !select_low_b_n_i;

  // command decode on the rising edge
  always_comb
  begin
    op_d = '{kind: ssc_pkg::KIND_NONE, addr: addr_i,
             ben_n: byte_lane_enables_n_i};
    last_d = last_q;
    hi_d = hi_q;
    load = 1'b0;
    step = 1'b0;
    if (!frozen)
    begin
      if (!load_or_advance_i)
      begin
        if (!sel_ok)
          last_d = ssc_pkg::KIND_DESEL;
        else if (write_n_i)
        begin
          op_d.kind = ssc_pkg::KIND_READ;
          last_d = ssc_pkg::KIND_READ;
          load = 1'b1;
          hi_d = addr_i[`SSC_AW-1:`SSC_BURST_W];
        end
        else if (ssc_pkg::any_lane(byte_lane_enables_n_i)
                 && st_q != ssc_pkg::ST_WAKE)
        begin
          op_d.kind = ssc_pkg::KIND_WRITE;
          last_d = ssc_pkg::KIND_WRITE;
          load = 1'b1;
          hi_d = addr_i[`SSC_AW-1:`SSC_BURST_W];
        end
        else
          last_d = ssc_pkg::KIND_DESEL;
      end
      else
      begin
        // continue: chip selects and write select do not matter
        step = 1'b1;
        op_d.addr = {hi_q, next_low};
        if (last_q == ssc_pkg::KIND_READ)
          op_d.kind = ssc_pkg::KIND_READ;
        else if (last_q == ssc_pkg::KIND_WRITE
                 && st_q != ssc_pkg::ST_WAKE)
          op_d.kind = ssc_pkg::KIND_WRITE;
        else
          op_d.kind = ssc_pkg::KIND_NONE;
      end
    end
  end

  // burst counter for the low address bits
  ssc_burst_gen u_burst (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .load_i(load),
    .step_i(step),
    .start_i(addr_i[`SSC_BURST_W-1:0]),
    .interleave_i(strap_q.interleave),
    .next_o(next_low)
  );

  // pipeline and data path; flow-through taps the first stage,
  // pipelined mode taps the second, so both modes share one datapath
  always_comb
  begin
    s1_d = frozen ? s1_q : op_d;
    s2_d = frozen ? s2_q : s1_q;
    re_d = frozen ? re_q : (op_d.kind == ssc_pkg::KIND_READ);
    rd_d = frozen ? rd_q : mem_rdata_i;
    wsrc = strap_q.flow ? s1_q : s2_q;
    dq_d = dq_q;
    rdv_d = rdv_q;
    if (!frozen)
    begin
      dq_d = strap_q.flow ? mem_rdata_i : rd_q;
      rdv_d = strap_q.flow ? (s1_q.kind == ssc_pkg::KIND_READ)
                           : (s2_q.kind == ssc_pkg::KIND_READ);
    end
    // output enable and sleep override the drive at any time
    // only read beats set rdv, so a write never turns the drivers on
    oe_d = rdv_d && !out_enable_n_i && !sleep_request_i
           && (st_q != ssc_pkg::ST_ASLEEP);
    // write data taken at the stage's edge; no lanes means no write
    we_d = !frozen && (wsrc.kind == ssc_pkg::KIND_WRITE)
           && ssc_pkg::any_lane(wsrc.ben_n);
    waddr_d = we_d ? wsrc.addr : waddr_q;
    wben_d = we_d ? ~wsrc.ben_n : wben_q;
    wdata_d = we_d ? dq_i : wdata_q;
  end

  // register every group; outputs float from reset
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      strap_q <= '{flow: 1'b0, interleave: 1'b0, high_drive: 1'b0};
      strap_taken_q <= 1'b0;
      st_q <= ssc_pkg::ST_ACTIVE;
      slp_cnt_q <= `SSC_SLEEP_START;
      asleep_q <= 1'b0;
      last_q <= ssc_pkg::KIND_DESEL;
      hi_q <= '0;
      s1_q <= '0;
      s2_q <= '0;
      re_q <= 1'b0;
      rd_q <= '0;
      dq_q <= '0;
      rdv_q <= 1'b0;
      oe_q <= 1'b0;
      we_q <= 1'b0;
      waddr_q <= '0;
      wben_q <= '0;
      wdata_q <= '0;
    end
    else
    begin
      strap_q <= strap_d;
      strap_taken_q <= strap_taken_d;
      st_q <= st_d;
      slp_cnt_q <= slp_cnt_d;
      asleep_q <= asleep_d;
      last_q <= last_d;
      hi_q <= hi_d;
      s1_q <= s1_d;
      s2_q <= s2_d;
      re_q <= re_d;
      rd_q <= rd_d;
      dq_q <= dq_d;
      rdv_q <= rdv_d;
      oe_q <= oe_d;
      we_q <= we_d;
      waddr_q <= waddr_d;
      wben_q <= wben_d;
      wdata_q <= wdata_d;
    end
  end

  // outputs come straight from flip-flops
  assign dq_o = dq_q;
  assign dq_oe_o = oe_q;
  assign mem_re_o = re_q;
  assign mem_raddr_o = s1_q.addr;
  assign mem_we_o = we_q;
  assign mem_waddr_o = waddr_q;
  assign mem_wben_o = wben_q;
  assign mem_wdata_o = wdata_q;
  assign high_drive_o = strap_q.high_drive;
  assign asleep_o = asleep_q;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  rd_start_a: assert property (
    !frozen && !load_or_advance_i && sel_ok && write_n_i
      |=> s1_q.kind == ssc_pkg::KIND_READ && s1_q.addr == $past(addr_i))
    else $error("read start not registered");

  wr_start_a: assert property (
    !frozen && !load_or_advance_i && sel_ok && !write_n_i
      && ssc_pkg::any_lane(byte_lane_enables_n_i)
      && st_q != ssc_pkg::ST_WAKE
      |=> s1_q.kind == ssc_pkg::KIND_WRITE && s1_q.addr == $past(addr_i))
    else $error("write start not registered");

  abort_none_a: assert property (
    mem_we_o |-> mem_wben_o != '0)
    else $error("write issued with no lanes");

  desel_float_a: assert property (
    !frozen && !load_or_advance_i && !sel_ok
      |=> s1_q.kind == ssc_pkg::KIND_NONE)
    else $error("deselect did not idle the stage");

  desel_cont_a: assert property (
    !frozen && load_or_advance_i && last_q == ssc_pkg::KIND_DESEL
      |=> s1_q.kind == ssc_pkg::KIND_NONE && last_q == ssc_pkg::KIND_DESEL)
    else $error("continue after deselect left deselect");

  hold_freeze_a: assert property (
    clock_hold_i |=> $stable(s1_q) && $stable(s2_q) && $stable(last_q)
                     && !mem_we_o)
    else $error("held edge changed state");

  write_no_drive_a: assert property (
    mem_we_o |-> !dq_oe_o)
    else $error("bus driven during a write");

  pipe_write_lat_a: assert property (
    !frozen && !strap_q.flow && !load_or_advance_i
      && sel_ok && !write_n_i && ssc_pkg::any_lane(byte_lane_enables_n_i)
      && st_q == ssc_pkg::ST_ACTIVE && !sleep_request_i
      ##1 !clock_hold_i && !sleep_request_i ##1 !clock_hold_i
      |=> mem_we_o && mem_wdata_o == $past(dq_i))
    else $error("pipelined write data not taken on third edge");

  flow_write_lat_a: assert property (
    !frozen && strap_q.flow && !load_or_advance_i && sel_ok
      && !write_n_i && ssc_pkg::any_lane(byte_lane_enables_n_i)
      && st_q == ssc_pkg::ST_ACTIVE && !sleep_request_i
      ##1 !clock_hold_i
      |=> mem_we_o && mem_wdata_o == $past(dq_i))
    else $error("flow-through write data not taken on second edge");

  sleep_float_a: assert property (
    sleep_request_i |=> !dq_oe_o)
    else $error("data driven while sleep requested");

  sleep_enter_a: assert property (
    st_q == ssc_pkg::ST_ACTIVE && sleep_request_i ##1 sleep_request_i
      |=> asleep_o)
    else $error("sleep not entered after two edges");

endmodule : ssc_core
`default_nettype wire

// [logic/ssc_fix_note.sv]
// empty unit: the block keeps no logic in this file
`default_nettype none
`default_nettype wire

// [verification/ssc_ctrl_model.sv]
// memory controller model: drives commands and late write data
`default_nettype none
`include "ssc_defines.svh"
module ssc_ctrl_model (
  input wire logic clk_i,
  input wire logic flow_i,
  output logic hold_o,
  output logic cont_o,
  output logic w_n_o,
  output logic [`SSC_LANES-1:0] ben_n_o,
  output logic [2:0] sel_o,
  output logic [`SSC_AW-1:0] addr_o,
  output logic [`SSC_DW-1:0] dq_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [`SSC_DW-1:0] wd_q; // data owed by the command now driven
  logic [`SSC_DW-1:0] p_d; // data owed one edge later
  logic p_v; // p_d is real write data
  logic last_wr; // prior burst was a write with lanes
  logic sel_ok;
  logic lanes;
  logic wr_now;
  // sel_o is {low a, high, low b}; only 3'h2 selects
  assign sel_ok = (sel_o == 3'h2);
  assign lanes = (ben_n_o != 4'hf);
  // a continue owes data only after a real write begin
  assign wr_now = lanes && (cont_o ? last_wr : (sel_ok && !w_n_o));
  // idle state: deselected, no data owed
  initial
  begin
    {hold_o, cont_o, w_n_o, p_v, last_wr} = 5'h04;
    ben_n_o = 4'hf;
    sel_o = 3'h7;
    addr_o = '0;
    {dq_o, wd_q, p_d} = '0;
  end
  // frozen on hold edges; idle data flips each cycle so it never looks valid
  always @(posedge clk_i)
  begin
    if (!hold_o)
    begin
      if (!cont_o)
        last_wr <= sel_ok && !w_n_o && lanes;
      p_v <= wr_now;
      p_d <= wd_q;
      if (flow_i ? wr_now : p_v)
        dq_o <= flow_i ? wd_q : p_d;
      else
        dq_o <= ~dq_o;
    end
  end
  // one command, launched just after an edge, sampled at the next
  task automatic cmd(input logic h, v, wn, input logic [3:0] b,
    input logic [2:0] s, input logic [`SSC_AW-1:0] a,
    input logic [`SSC_DW-1:0] d);
    @(posedge clk_i);
    hold_o <= h;
    cont_o <= v;
    w_n_o <= wn;
    ben_n_o <= b;
    sel_o <= s;
    addr_o <= a;
    wd_q <= d;
  endtask : cmd
endmodule : ssc_ctrl_model
`default_nettype wire

// [verification/ssc_core_test.sv]
// self-checking bench for the burst ram control core
`default_nettype none
`include "ssc_defines.svh"
module ssc_core_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic oe_n = 1'b0;
  logic sleep_req = 1'b0;
  logic order_sel = 1'b0;
  logic pt_sel_n = 1'b1;
  logic drv_sel = 1'b1;
  logic hold, cont, w_n;
  logic [2:0] sel;
  logic [3:0] ben, wben;
  logic [20:0] addr, raddr, waddr;
  logic [35:0] dqi, dq_o, wdata, rdata;
  logic dq_oe, re, we, hd, asleep;
  int cyc = 0;
  int err_count = 0;
  int n_compared = 0;
  int rd_t[$], wr_t[$];
  logic [35:0] rd_v[$], wr_v[$];
  logic [20:0] wr_a[$], ra[$];
  logic [3:0] wr_b[$];
  // array stand-in: data is a pattern of the address
  assign rdata = {raddr[14:0], raddr};
  always #5 clk_i = ~clk_i;
  ssc_ctrl_model ssc_ctrl_model_i (.clk_i(clk_i), .flow_i(!pt_sel_n),
    .hold_o(hold), .cont_o(cont), .w_n_o(w_n), .ben_n_o(ben), .sel_o(sel),
    .addr_o(addr), .dq_o(dqi));
  ssc_core ssc_core_i (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .clock_hold_i(hold), .load_or_advance_i(cont), .write_n_i(w_n),
    .byte_lane_enables_n_i(ben), .select_low_a_n_i(sel[2]),
    .select_high_i(sel[1]), .select_low_b_n_i(sel[0]),
    .out_enable_n_i(oe_n), .sleep_request_i(sleep_req),
    .burst_order_select_i(order_sel), .pass_through_select_n_i(pt_sel_n),
    .drive_strength_select_i(drv_sel), .addr_i(addr), .dq_i(dqi),
    .mem_rdata_i(rdata), .dq_o(dq_o), .dq_oe_o(dq_oe), .mem_re_o(re),
    .mem_raddr_o(raddr), .mem_we_o(we), .mem_waddr_o(waddr),
    .mem_wben_o(wben), .mem_wdata_o(wdata), .high_drive_o(hd),
    .asleep_o(asleep));
  // log outputs once settled after each edge, stamped with the edge number
  always @(posedge clk_i)
  begin
    #1;
    cyc++;
    if (dq_oe)
    begin
      rd_t.push_back(cyc);
      rd_v.push_back(dq_o);
    end
    if (we)
    begin
      wr_t.push_back(cyc);
      wr_v.push_back(wdata);
      wr_a.push_back(waddr);
      wr_b.push_back(wben);
    end
    if (re)
      ra.push_back(raddr);
  end
  task automatic cmp(input string what, input logic [35:0] exp, got);
    n_compared++;
    if (got !== exp)
    begin
      err_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp
  task automatic stop_test;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : stop_test
  task automatic clr;
    rd_t.delete();
    wr_t.delete();
    rd_v.delete();
    wr_v.delete();
    wr_a.delete();
    ra.delete();
    wr_b.delete();
  endtask : clr
  task automatic idle(input int n);
    repeat (n) ssc_ctrl_model_i.cmd(0, 0, 1, 4'hf, 3'h7, 0, 0);
  endtask : idle
  // straps are caught at the first edge after release
  task automatic do_reset(input logic o, p, d);
    @(posedge clk_i);
    rst_n_i <= 1'b0;
    order_sel <= o;
    pt_sel_n <= p;
    drv_sel <= d;
    repeat (6) @(posedge clk_i);
    cmp("oe in reset", 0, dq_oe);
    cmp("we in reset", 0, we);
    rst_n_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    cmp("drive", !d, hd);
  endtask : do_reset
  // load then four continues; fifth access wraps to the base
  task automatic t_burst(input logic ilv, input int lat);
    logic [20:0] a;
    int e;
    a = 21'h12345;
    clr();
    ssc_ctrl_model_i.cmd(0, 0, 1, 4'hf, 3'h2, a, 0);
    e = cyc + 2;
    repeat (4) ssc_ctrl_model_i.cmd(0, 1, 1, 4'hf, 3'h7, 0, 0);
    idle(4);
    cmp("burst len", 5, ra.size());
    cmp("read len", 5, rd_v.size());
    for (int i = 0; i < 5; i++)
    begin
      a[1:0] = ilv ? (2'h1 ^ i[1:0]) : (2'h1 + i[1:0]);
      cmp("burst addr", a, ra[i]);
      cmp("read data", {a[14:0], a}, rd_v[i]);
      cmp("read time", e + lat + i, rd_t[i]);
    end
    $display("test burst done");
  endtask : t_burst
  // write begin, continue, holds, then an abort and a continue after it
  task automatic t_write(input int t0, t1);
    logic [20:0] a;
    int e;
    a = 21'h00a02;
    clr();
    ssc_ctrl_model_i.cmd(0, 0, 0, 4'h5, 3'h2, a, 36'h123456789);
    e = cyc + 2;
    ssc_ctrl_model_i.cmd(0, 1, 1, 4'h0, 3'h7, 0, 36'h9abcdef01);
    repeat (2) ssc_ctrl_model_i.cmd(1, 0, 0, 4'h0, 3'h2, 0, 0);
    ssc_ctrl_model_i.cmd(0, 0, 0, 4'hf, 3'h2, 21'h7, 0);
    ssc_ctrl_model_i.cmd(0, 1, 0, 4'h0, 3'h2, 0, 0);
    idle(4);
    cmp("writes", 2, wr_t.size());
    cmp("driven", 0, rd_v.size());
    cmp("waddr0", a, wr_a[0]);
    cmp("waddr1", a + 21'h1, wr_a[1]);
    cmp("lanes0", 4'ha, wr_b[0]);
    cmp("lanes1", 4'hf, wr_b[1]);
    cmp("wdata0", 36'h123456789, wr_v[0]);
    cmp("wdata1", 36'h9abcdef01, wr_v[1]);
    cmp("wtime0", e + t0, wr_t[0]);
    cmp("wtime1", e + t1, wr_t[1]);
    $display("test write done");
  endtask : t_write
  // holds after read data appears keep it on the bus unchanged
  task automatic t_hold;
    int e;
    clr();
    ssc_ctrl_model_i.cmd(0, 0, 1, 4'hf, 3'h2, 21'h1f0f0, 0);
    e = cyc + 2;
    idle(2);
    repeat (3) ssc_ctrl_model_i.cmd(1, 0, 1, 4'hf, 3'h2, 0, 0);
    idle(3);
    cmp("hold beats", 4, rd_v.size());
    cmp("hold start", e + 2, rd_t[0]);
    for (int i = 0; i < 4; i++)
      cmp("hold data", {15'h70f0, 21'h1f0f0}, rd_v[i]);
    $display("test hold done");
  endtask : t_hold
  // reads with output enable high happen but never drive
  task automatic t_oe;
    clr();
    @(posedge clk_i);
    oe_n <= 1'b1;
    ssc_ctrl_model_i.cmd(0, 0, 1, 4'hf, 3'h2, 21'h55, 0);
    ssc_ctrl_model_i.cmd(0, 1, 1, 4'hf, 3'h2, 0, 0);
    idle(4);
    oe_n <= 1'b0;
    cmp("dummy reads", 2, ra.size());
    cmp("dummy drive", 0, rd_v.size());
    $display("test output enable done");
  endtask : t_oe
  // sleep entry takes two edges; commands while asleep do nothing
  task automatic t_sleep;
    clr();
    @(posedge clk_i);
    sleep_req <= 1'b1;
    @(posedge clk_i);
    #1 cmp("early sleep", 0, asleep);
    @(posedge clk_i);
    #1 cmp("asleep", 1, asleep);
    ssc_ctrl_model_i.cmd(0, 0, 1, 4'hf, 3'h2, 21'h9, 0);
    idle(3);
    cmp("sleep reads", 0, ra.size());
    cmp("sleep drive", 0, rd_v.size());
    sleep_req <= 1'b0;
    repeat (3) @(posedge clk_i);
    #1 cmp("awake", 0, asleep);
    $display("test sleep done");
  endtask : t_sleep
  // each select off in turn, then a continue after the deselect
  task automatic t_desel;
    clr();
    for (int i = 0; i < 3; i++)
      ssc_ctrl_model_i.cmd(0, 0, 1, 4'h0, 3'h2 ^ (3'h1 << i), 21'h40, 0);
    ssc_ctrl_model_i.cmd(0, 1, 1, 4'h0, 3'h2, 0, 0);
    idle(4);
    cmp("desel reads", 0, ra.size());
    cmp("desel drive", 0, rd_v.size());
    $display("test deselect done");
  endtask : t_desel
  initial
  begin
    do_reset(0, 1, 1);
    t_burst(0, 2);
    t_write(4, 5);
    t_hold();
    t_oe();
    t_sleep();
    t_desel();
    do_reset(1, 0, 0);
    t_burst(1, 1);
    t_write(1, 4);
    stop_test();
  end
  // cuts a hang short
  initial
  begin
    repeat (3000) @(posedge clk_i);
    err_count++;
    stop_test();
  end
endmodule : ssc_core_test
`default_nettype wire
